// ==== rtl/atx_ctrl_regs.sv ====
// Control-register slice of the audio transmitter: interrupt trigger modes,
// masks and status, interrupt pin, buffer controls, buffer window, identity.
// Assumes the serial control port has already decoded a byte access into
// pointer, data and one-cycle strobes on i_clock; event inputs come from
// transmitter logic on the same clock.
`default_nettype none

module atx_ctrl_regs #(
  parameter logic [3:0] PART_CODE        = 4'h5, // Arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h3  // Arbitrary value
) (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic [6:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  input  wire logic        i_source_slip_event,
  input  wire logic        i_cs_xfer_event,
  input  wire logic        i_ub_xfer_event,
  input  wire logic        i_enc_pos,
  input  wire logic        i_enc_neg,
  input  wire logic [5:0]  i_eng_addr,
  output logic      [7:0]  o_eng_rdata,
  output logic             o_cs_xfer_allow,
  output logic             o_ub_xfer_allow,
  output logic             o_cs_port_access_width,
  output logic             o_user_bit_source_sel,
  output logic      [1:0]  o_user_bit_manager_mode,
  output logic             o_irq_pin,
  output logic             o_irq_oe_n,
  output logic             o_line_drive_pos,
  output logic             o_line_drive_neg,
  output logic             o_low_power
);

  // Whole register state of the slice
  typedef struct packed {
    logic [1:0] irq_pol;     // Interrupt pin polarity field
    logic [2:0] code_hi;     // Trigger code high bits per source
    logic [2:0] code_lo;     // Trigger code low bits per source
    logic [2:0] mask;        // Unmask bits per source
    logic [2:0] status;      // Sticky status per source
    logic [2:0] src_prev;    // Source level one cycle ago
    logic       buffer_window_select;        // Window bank select
    logic       cs_inh;      // Channel-status transfer inhibit
    logic       cs_port_access_width;         // Channel-status port access width
    logic       ud;          // User bit source
    logic [1:0] ubm;         // User bit manager mode
    logic       ub_inh;      // User transfer inhibit
    logic       rd_pend;     // Read answer due next cycle
    logic       rd_mem;      // Pending read comes from buffer
    logic [7:0] rd_hold;     // Register value caught at the request
    logic [7:0] rdata;       // Read answer
    logic       rvalid;      // Read answer strobe
    logic       irq_pin;     // Registered pin level
    logic       irq_oe_n;    // Registered pin enable, low drives
    logic       drv_pos;     // Registered line driver, positive
    logic       drv_neg;     // Registered line driver, negative
  } atx_state_t;

  atx_state_t state_reg;     // Current state
  atx_state_t state_next;    // Next state

  logic       rst_meta_reg;  // Reset release, first stage
  logic       rst_sync_reg;  // Reset release, used copy
  logic [2:0] src_now;       // Source conditions this cycle
  logic [2:0] src_event;     // Trigger hits this cycle
  logic [2:0] src_live_lvl;  // Level-mode sources still true
  logic [1:0] trig_code [atx_pkg::NUM_SRC];
  logic       in_window;     // Pointer inside buffer window
  logic       win_usable;    // Selected bank may be reached
  logic [5:0] win_index;     // Memory address for the window
  logic [6:0] win_offset;    // Pointer minus window base
  logic [7:0] buf_rdata;     // Buffer read word
  logic [7:0] reg_view;      // Register read value, combinational
  logic       irq_active;    // Any status bit set

  // reset release; the whole slice is held while the pin is low
  // and the release goes through two flops to avoid a ragged exit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // User transfer source only exists in block mode
  assign src_now[atx_pkg::SRC_SLIP] = i_source_slip_event;
  assign src_now[atx_pkg::SRC_CSX]  = i_cs_xfer_event;
  assign src_now[atx_pkg::SRC_UBX]  = i_ub_xfer_event
                                      & (state_reg.ubm == atx_pkg::UBM_BLOCK);

  // Per-source trigger decode
  for (genvar s = 0; s < atx_pkg::NUM_SRC; s++) begin : g_trig
    // two register bits form the code
    assign trig_code[s] = {state_reg.code_hi[s], state_reg.code_lo[s]};

    always_comb begin
      src_live_lvl[s] = 1'b0;
      unique case (trig_code[s])
        atx_pkg::TRIG_FALL: src_event[s] = ~src_now[s] & state_reg.src_prev[s];
        atx_pkg::TRIG_LEVEL: begin
          src_event[s]    = src_now[s];
          src_live_lvl[s] = src_now[s];
        end
        // the reserved code falls in here too
        default: src_event[s] = src_now[s] & ~state_reg.src_prev[s];
      endcase
    end
  end

  // Window mapping
  assign win_offset = i_reg_addr - atx_pkg::OFS_WIN_FIRST;
  // window range and user bank only in block mode
  assign in_window  = (i_reg_addr >= atx_pkg::OFS_WIN_FIRST)
                    & (i_reg_addr <= atx_pkg::OFS_WIN_LAST);
  assign win_usable = in_window
                    & (~state_reg.buffer_window_select | (state_reg.ubm == atx_pkg::UBM_BLOCK));
  // bank bit keeps the two buffer sets apart
  assign win_index  = {state_reg.buffer_window_select, win_offset[4:0]};

  // Buffer storage; port b feeds the transfer engine
  atx_side_buf u_side_buf (
    .i_clock   (i_clock),
    .i_rst_n   (rst_sync_reg),
    .i_wr      (i_reg_wr & win_usable),
    .i_waddr   (win_index),
    .i_wdata   (i_reg_wdata),
    .i_raddr_a (win_index),
    .o_rdata_a (buf_rdata),
    .i_raddr_b (i_eng_addr),
    .o_rdata_b (o_eng_rdata)
  );

  // Register read view at the current pointer
  always_comb begin
    reg_view = atx_pkg::RST_BYTE;
    unique case (i_reg_addr)
      atx_pkg::OFS_CTRL1: begin
        reg_view[atx_pkg::POL_MSB:atx_pkg::POL_LSB] = state_reg.irq_pol;
      end
      atx_pkg::OFS_IRQ1_STAT: begin
        reg_view[atx_pkg::SLIP_BIT] = state_reg.status[atx_pkg::SRC_SLIP];
        reg_view[atx_pkg::CSX_BIT]  = state_reg.status[atx_pkg::SRC_CSX];
      end
      atx_pkg::OFS_IRQ2_STAT: begin
        reg_view[atx_pkg::UBX_BIT] = state_reg.status[atx_pkg::SRC_UBX];
      end
      atx_pkg::OFS_IRQ1_MASK: begin
        reg_view[atx_pkg::SLIP_BIT] = state_reg.mask[atx_pkg::SRC_SLIP];
        reg_view[atx_pkg::CSX_BIT]  = state_reg.mask[atx_pkg::SRC_CSX];
      end
      atx_pkg::OFS_IRQ1_HI: begin
        reg_view[atx_pkg::SLIP_BIT] = state_reg.code_hi[atx_pkg::SRC_SLIP];
        reg_view[atx_pkg::CSX_BIT]  = state_reg.code_hi[atx_pkg::SRC_CSX];
      end
      atx_pkg::OFS_IRQ1_LO: begin
        reg_view[atx_pkg::SLIP_BIT] = state_reg.code_lo[atx_pkg::SRC_SLIP];
        reg_view[atx_pkg::CSX_BIT]  = state_reg.code_lo[atx_pkg::SRC_CSX];
      end
      atx_pkg::OFS_IRQ2_MASK: begin
        reg_view[atx_pkg::UBX_BIT] = state_reg.mask[atx_pkg::SRC_UBX];
      end
      atx_pkg::OFS_IRQ2_HI: begin
        reg_view[atx_pkg::UBX_BIT] = state_reg.code_hi[atx_pkg::SRC_UBX];
      end
      atx_pkg::OFS_IRQ2_LO: begin
        reg_view[atx_pkg::UBX_BIT] = state_reg.code_lo[atx_pkg::SRC_UBX];
      end
      atx_pkg::OFS_CS_BUF_CTL: begin
        reg_view[atx_pkg::BUF_SEL_BIT]  = state_reg.buffer_window_select;
        reg_view[atx_pkg::CS_INH_BIT]   = state_reg.cs_inh;
        reg_view[atx_pkg::CS_WIDTH_BIT] = state_reg.cs_port_access_width;
      end
      atx_pkg::OFS_UB_BUF_CTL: begin
        reg_view[atx_pkg::UB_SRC_BIT] = state_reg.ud;
        reg_view[atx_pkg::UB_MODE_MSB:atx_pkg::UB_MODE_LSB] = state_reg.ubm;
        reg_view[atx_pkg::UB_INH_BIT] = state_reg.ub_inh;
      end
      atx_pkg::OFS_IDENT: reg_view = {PART_CODE, SILICON_REVISION};
      // Unmapped offsets and the window read as zero here
      default: reg_view = atx_pkg::RST_BYTE;
    endcase
  end

  // pin stays active until every status bit is back at zero
  assign irq_active = |state_reg.status;

  // Next-state logic for the whole slice
  always_comb begin
    state_next          = state_reg;
    state_next.src_prev = src_now;
    state_next.rvalid   = 1'b0;

    // Register writes; read-only offsets simply ignore them
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        atx_pkg::OFS_CTRL1: begin
          state_next.irq_pol = i_reg_wdata[atx_pkg::POL_MSB:atx_pkg::POL_LSB];
        end
        atx_pkg::OFS_IRQ1_MASK: begin
          state_next.mask[atx_pkg::SRC_SLIP] = i_reg_wdata[atx_pkg::SLIP_BIT];
          state_next.mask[atx_pkg::SRC_CSX]  = i_reg_wdata[atx_pkg::CSX_BIT];
        end
        // slip at bit 7, CS at bit 1
        atx_pkg::OFS_IRQ1_HI: begin
          state_next.code_hi[atx_pkg::SRC_SLIP] = i_reg_wdata[atx_pkg::SLIP_BIT];
          state_next.code_hi[atx_pkg::SRC_CSX]  = i_reg_wdata[atx_pkg::CSX_BIT];
        end
        atx_pkg::OFS_IRQ1_LO: begin
          state_next.code_lo[atx_pkg::SRC_SLIP] = i_reg_wdata[atx_pkg::SLIP_BIT];
          state_next.code_lo[atx_pkg::SRC_CSX]  = i_reg_wdata[atx_pkg::CSX_BIT];
        end
        // user transfer unmask at bit 2
        atx_pkg::OFS_IRQ2_MASK: begin
          state_next.mask[atx_pkg::SRC_UBX] = i_reg_wdata[atx_pkg::UBX_BIT];
        end
        atx_pkg::OFS_IRQ2_HI: begin
          state_next.code_hi[atx_pkg::SRC_UBX] = i_reg_wdata[atx_pkg::UBX_BIT];
        end
        atx_pkg::OFS_IRQ2_LO: begin
          state_next.code_lo[atx_pkg::SRC_UBX] = i_reg_wdata[atx_pkg::UBX_BIT];
        end
        atx_pkg::OFS_CS_BUF_CTL: begin
          state_next.buffer_window_select   = i_reg_wdata[atx_pkg::BUF_SEL_BIT];
          state_next.cs_inh = i_reg_wdata[atx_pkg::CS_INH_BIT];
          state_next.cs_port_access_width    = i_reg_wdata[atx_pkg::CS_WIDTH_BIT];
        end
        atx_pkg::OFS_UB_BUF_CTL: begin
          state_next.ud     = i_reg_wdata[atx_pkg::UB_SRC_BIT];
          state_next.ubm    = i_reg_wdata[atx_pkg::UB_MODE_MSB:atx_pkg::UB_MODE_LSB];
          state_next.ub_inh = i_reg_wdata[atx_pkg::UB_INH_BIT];
        end
        default: ;
      endcase
    end

    // status read clears, but a live level source keeps its bit
    if (i_reg_rd && (i_reg_addr == atx_pkg::OFS_IRQ1_STAT)) begin
      state_next.status[atx_pkg::SRC_SLIP] = 1'b0;
      state_next.status[atx_pkg::SRC_CSX]  = 1'b0;
    end
    if (i_reg_rd && (i_reg_addr == atx_pkg::OFS_IRQ2_STAT)) begin
      state_next.status[atx_pkg::SRC_UBX] = 1'b0;
    end
    // Setting comes after the clear so a same-cycle event is never lost
    state_next.status = state_next.status | src_event | src_live_lvl;
    // masked sources never show in status nor reach the pin
    state_next.status = state_next.status & state_next.mask;

    // Read pipeline: catch the value now, answer two edges after request
    state_next.rd_pend = i_reg_rd;
    if (i_reg_rd) begin
      state_next.rd_hold = reg_view;
      state_next.rd_mem  = win_usable;
    end
    if (state_reg.rd_pend) begin
      state_next.rdata  = state_reg.rd_mem ? buf_rdata : state_reg.rd_hold;
      state_next.rvalid = 1'b1;
    end

    // pin level decided by the polarity field and whether any status bit is set
    // high, low, open-drain low; reserved behaves as high
    unique case (state_reg.irq_pol)
      atx_pkg::POL_LOW: begin
        state_next.irq_pin  = ~irq_active;
        state_next.irq_oe_n = 1'b0;
      end
      atx_pkg::POL_OD_LOW: begin
        state_next.irq_pin  = 1'b0;
        state_next.irq_oe_n = ~irq_active;
      end
      default: begin
        state_next.irq_pin  = irq_active;
        state_next.irq_oe_n = 1'b0;
      end
    endcase

    // Line drivers follow the encoder once out of reset
    state_next.drv_pos = i_enc_pos;
    state_next.drv_neg = i_enc_neg;
  end

  // State register
  // every field, trigger codes included, clears to zero
  // line drivers sit low for the whole reset
  always_ff @(posedge i_clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Engine-facing controls; user transfers only exist in block mode
  assign o_cs_xfer_allow         = ~state_reg.cs_inh;
  assign o_ub_xfer_allow         = (state_reg.ubm == atx_pkg::UBM_BLOCK)
                                 & ~state_reg.ub_inh;
  assign o_cs_port_access_width  = state_reg.cs_port_access_width;
  assign o_user_bit_source_sel   = state_reg.ud;
  assign o_user_bit_manager_mode = state_reg.ubm;

  // Pins and read answer straight from flops
  assign o_reg_rdata      = state_reg.rdata;
  assign o_reg_rvalid     = state_reg.rvalid;
  assign o_irq_pin        = state_reg.irq_pin;
  assign o_irq_oe_n       = state_reg.irq_oe_n;
  assign o_line_drive_pos = state_reg.drv_pos;
  assign o_line_drive_neg = state_reg.drv_neg;
  assign o_low_power      = ~rst_sync_reg;

endmodule

`default_nettype wire

// ==== rtl/atx_pkg.sv ====
// Shared constants of the transmitter control-register slice: offsets,
// field positions, codes and reset values.
// Assumes one 10 MHz clock and a byte-wide register port in front of it.
`default_nettype none

package atx_pkg;

  // Register offsets on the seven-bit register pointer
  localparam logic [6:0] OFS_CTRL1      = 7'h01;
  localparam logic [6:0] OFS_IRQ1_STAT  = 7'h07;
  localparam logic [6:0] OFS_IRQ2_STAT  = 7'h08;
  localparam logic [6:0] OFS_IRQ1_MASK  = 7'h09;
  localparam logic [6:0] OFS_IRQ1_HI    = 7'h0a;
  localparam logic [6:0] OFS_IRQ1_LO    = 7'h0b;
  localparam logic [6:0] OFS_IRQ2_MASK  = 7'h0c;
  localparam logic [6:0] OFS_IRQ2_HI    = 7'h0d;
  localparam logic [6:0] OFS_IRQ2_LO    = 7'h0e;
  localparam logic [6:0] OFS_CS_BUF_CTL = 7'h12;
  localparam logic [6:0] OFS_UB_BUF_CTL = 7'h13;
  localparam logic [6:0] OFS_WIN_FIRST  = 7'h20;
  localparam logic [6:0] OFS_WIN_LAST   = 7'h37;
  localparam logic [6:0] OFS_IDENT      = 7'h7f;

  // Interrupt source bit positions inside the status, mask and mode bytes
  localparam int SLIP_BIT = 7;
  localparam int CSX_BIT  = 1;
  localparam int UBX_BIT  = 2;

  // Source index inside the internal three-bit vectors
  localparam int SRC_SLIP = 0;
  localparam int SRC_CSX  = 1;
  localparam int SRC_UBX  = 2;
  localparam int NUM_SRC  = 3;

  // Control 1 polarity field position
  localparam int POL_LSB = 1;
  localparam int POL_MSB = 2;

  // Buffer control field positions
  localparam int BUF_SEL_BIT   = 5;
  localparam int CS_INH_BIT    = 2;
  localparam int CS_WIDTH_BIT  = 1;
  localparam int UB_SRC_BIT    = 4;
  localparam int UB_MODE_LSB   = 2;
  localparam int UB_MODE_MSB   = 3;
  localparam int UB_INH_BIT    = 0;

  // Trigger codes {hi, lo}
  localparam logic [1:0] TRIG_RISE  = 2'h0;
  localparam logic [1:0] TRIG_FALL  = 2'h1;
  localparam logic [1:0] TRIG_LEVEL = 2'h2;

  // Interrupt pin polarity codes
  localparam logic [1:0] POL_HIGH   = 2'h0;
  localparam logic [1:0] POL_LOW    = 2'h1;
  localparam logic [1:0] POL_OD_LOW = 2'h2;

  // User bit manager modes
  localparam logic [1:0] UBM_ZEROS  = 2'h0;
  localparam logic [1:0] UBM_BLOCK  = 2'h1;

  // Reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] RST_VEC3   = 3'h0;
  localparam logic [1:0] RST_CODE2  = 2'h0;

  // Buffer geometry: two banks of one window each
  localparam int         BUF_AW     = 6;
  localparam int         BUF_DEPTH  = 64;

endpackage

`default_nettype wire

// ==== rtl/atx_side_buf.sv ====
// Little two-bank memory holding the channel-status and user-bit E buffers.
// One write port, two read ports, each read word comes out of a register
// one clock after its address. Same clock as the register slice.
`default_nettype none

module atx_side_buf (
  input  wire logic                            i_clock,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_wr,
  input  wire logic [atx_pkg::BUF_AW-1:0]      i_waddr,
  input  wire logic [7:0]                      i_wdata,
  input  wire logic [atx_pkg::BUF_AW-1:0]      i_raddr_a,
  output logic      [7:0]                      o_rdata_a,
  input  wire logic [atx_pkg::BUF_AW-1:0]      i_raddr_b,
  output logic      [7:0]                      o_rdata_b
);

  // Storage has no reset: contents are undefined until software fills it
  logic [7:0] mem [atx_pkg::BUF_DEPTH];

  // Write port
  always_ff @(posedge i_clock) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read ports, cleared by reset so outputs are defined
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata_a <= atx_pkg::RST_BYTE;
      o_rdata_b <= atx_pkg::RST_BYTE;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end

endmodule

`default_nettype wire

// ==== testbench/atx_ctrl_props.sv ====
// Checker for the control-register slice; sees only the top module ports.
// Assumes the reset copy inside the design lags the reset pin by two edges.
`default_nettype none

module atx_ctrl_props #(
  parameter logic [3:0] PART_CODE        = 4'h5, // Arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h3  // Arbitrary value
) (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic [7:0] o_reg_rdata,
  input  wire logic       o_reg_rvalid,
  input  wire logic       i_enc_pos,
  input  wire logic       i_enc_neg,
  input  wire logic       o_cs_xfer_allow,
  input  wire logic       o_ub_xfer_allow,
  input  wire logic       o_cs_port_access_width,
  input  wire logic       o_user_bit_source_sel,
  input  wire logic [1:0] o_user_bit_manager_mode,
  input  wire logic       o_irq_pin,
  input  wire logic       o_irq_oe_n,
  input  wire logic       o_line_drive_pos,
  input  wire logic       o_line_drive_neg,
  input  wire logic       o_low_power
);
  // One clock domain, so one clocking for all and one default disable
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  // Reset checks must stay live while reset is asserted
  a_drivers_low_reset: assert property (disable iff (1'b0)
    !i_arst_n |-> !o_line_drive_pos && !o_line_drive_neg) else $error("drivers high in reset");
  a_low_power_reset: assert property (disable iff (1'b0)
    !i_arst_n |-> o_low_power) else $error("low power missing in reset");
  a_driver_follows_enc: assert property (!o_low_power && !$past(o_low_power) |->
    o_line_drive_pos == $past(i_enc_pos) && o_line_drive_neg == $past(i_enc_neg))
    else $error("line drivers do not follow encoder");
  a_ident_read_value: assert property (i_reg_rd && i_reg_addr == 7'h7f |->
    ##[2:3] (o_reg_rvalid && o_reg_rdata == {PART_CODE, SILICON_REVISION}))
    else $error("identity read wrong");
  a_unmapped_read_zero: assert property (i_reg_rd && i_reg_addr inside {[7'h38:7'h7e]} |->
    ##[2:3] (o_reg_rvalid && o_reg_rdata == 8'h00)) else $error("unmapped read not zero");
  a_cs_inhibit_write: assert property (i_reg_wr && i_reg_addr == 7'h12 |=>
    o_cs_xfer_allow == !$past(i_reg_wdata[2])) else $error("cs inhibit not applied");
  a_access_width_write: assert property (i_reg_wr && i_reg_addr == 7'h12 |=>
    o_cs_port_access_width == $past(i_reg_wdata[1])) else $error("access width wrong");
  a_ubm_mode_write: assert property (i_reg_wr && i_reg_addr == 7'h13 |=>
    o_user_bit_manager_mode == $past(i_reg_wdata[3:2])) else $error("manager mode wrong");
  a_user_src_write: assert property (i_reg_wr && i_reg_addr == 7'h13 |=>
    o_user_bit_source_sel == $past(i_reg_wdata[4])) else $error("user bit source wrong");
  a_ub_allow_write: assert property (i_reg_wr && i_reg_addr == 7'h13 |=>
    o_ub_xfer_allow == ($past(i_reg_wdata[3:2]) == 2'h1 && !$past(i_reg_wdata[0])))
    else $error("user transfer allow wrong");
  a_open_drain_pin: assert property (o_irq_oe_n |-> !o_irq_pin)
    else $error("pin high while released");
endmodule

bind atx_ctrl_regs atx_ctrl_props #(.PART_CODE(PART_CODE), .SILICON_REVISION(SILICON_REVISION))
  i_atx_ctrl_props (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_enc_pos(i_enc_pos),
  .i_enc_neg(i_enc_neg), .o_cs_xfer_allow(o_cs_xfer_allow), .o_ub_xfer_allow(o_ub_xfer_allow),
  .o_cs_port_access_width(o_cs_port_access_width),
  .o_user_bit_source_sel(o_user_bit_source_sel),
  .o_user_bit_manager_mode(o_user_bit_manager_mode), .o_irq_pin(o_irq_pin),
  .o_irq_oe_n(o_irq_oe_n), .o_line_drive_pos(o_line_drive_pos),
  .o_line_drive_neg(o_line_drive_neg), .o_low_power(o_low_power));

`default_nettype wire

// ==== testbench/atx_mcu_model.sv ====
// Microcontroller model: issues byte accesses on the decoded register port.
// Assumes one access per call, strobe held across exactly one sampling edge.
`default_nettype none

module atx_mcu_model (
  input  wire logic       i_clock,
  output logic      [6:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port at time zero
  initial begin
    o_reg_addr = 7'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = w;
    o_reg_rd = !w;
    @(posedge i_clock);
    #1;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    // Released lines flip, so a design leaning on stale values is caught
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the control-register slice.
// Assumes the checker is bound in and the model drives the register port.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] PC = 4'h9; // Arbitrary value
  localparam logic [3:0] RV = 4'h6; // Arbitrary value
  logic       clock = 1'b0;
  logic       arst_n, slip_ev, cs_ev, ub_ev, enc_pos, enc_neg;
  logic [5:0] eng_addr;
  wire  [6:0] reg_addr;
  wire        reg_wr, reg_rd, reg_rvalid, cs_allow, ub_allow, cs_width, ub_src;
  wire  [7:0] reg_wdata, reg_rdata, eng_rdata;
  wire  [1:0] ub_mode;
  wire        irq_pin, irq_oe_n, drv_pos, drv_neg, low_power;
  logic [7:0] exp_q [$];      // Expected read answers, oldest first
  logic [31:0] rng = 32'h88cd; // Xorshift state
  int         mismatches = 0;
  int         samples_checked = 0;
  logic [6:0] ra [7] = '{7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h12, 7'h13};
  logic [7:0] rm [7] = '{8'h82, 8'h82, 8'h04, 8'h04, 8'h04, 8'h26, 8'h15}; // Writable bits, except mode bit 3 of 0x13, which is kept at zero

  atx_ctrl_regs #(.PART_CODE(PC), .SILICON_REVISION(RV)) i_atx_ctrl_regs (
    .i_clock(clock), .i_arst_n(arst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .o_reg_rvalid(reg_rvalid), .i_source_slip_event(slip_ev), .i_cs_xfer_event(cs_ev),
    .i_ub_xfer_event(ub_ev), .i_enc_pos(enc_pos), .i_enc_neg(enc_neg), .i_eng_addr(eng_addr),
    .o_eng_rdata(eng_rdata), .o_cs_xfer_allow(cs_allow), .o_ub_xfer_allow(ub_allow),
    .o_cs_port_access_width(cs_width), .o_user_bit_source_sel(ub_src),
    .o_user_bit_manager_mode(ub_mode), .o_irq_pin(irq_pin), .o_irq_oe_n(irq_oe_n),
    .o_line_drive_pos(drv_pos), .o_line_drive_neg(drv_neg), .o_low_power(low_power));
  atx_mcu_model i_atx_mcu_model (.i_clock(clock), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata));

  // 10 MHz clock
  always #50 clock = ~clock;

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Encoder bits and masked event sources wander randomly all run
  always @(posedge clock) begin
    #1;
    {enc_pos, enc_neg, cs_ev, ub_ev} = 4'(rnd());
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Each read answer is matched against the oldest note
  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk(reg_rdata, 8'hxx, "unexpected answer");
      else
        chk(reg_rdata, exp_q.pop_front(), "read data");
    end
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_atx_mcu_model.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_atx_mcu_model.access(1'b0, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic conclude();
    $display("Counts: checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    // Pulse reset so the asynchronous clear sees a real falling edge
    arst_n = 1'b1;
    #1;
    arst_n = 1'b0;
    slip_ev = 1'b0;
    eng_addr = 6'h00;
    {enc_pos, enc_neg, cs_ev, ub_ev} = 4'hf;
    idle(19);
    #1;
    chk({6'h00, drv_pos, drv_neg}, 8'h00, "drivers in reset");
    chk({7'h00, low_power}, 8'h01, "low power in reset");
    idle(1);
    #1;
    // reset held until the clock is steady
    arst_n = 1'b1;
    idle(4);
    chk({7'h00, low_power}, 8'h00, "low power after release");
    for (int i = 0; i < 7; i++) rd(ra[i], 8'h00);
    for (int i = 0; i < 7; i++) begin
      d = 8'(rnd()) & rm[i];
      wr(ra[i], d);
      rd(ra[i], d);
    end
    wr(7'h0c, 8'h00);
    rd(7'h7f, {PC, RV});
    wr(7'h7f, 8'hff);
    rd(7'h7f, {PC, RV});
    rd(7'h50, 8'h00);
    $display("Test done: reset values, read-back, identity");
    d = 8'(rnd());
    e = 8'(rnd());
    wr(7'h13, 8'h04);
    wr(7'h12, 8'h00);
    wr(7'h20, d);
    wr(7'h37, e);
    wr(7'h12, 8'h20);
    wr(7'h20, ~d);
    rd(7'h20, ~d);
    wr(7'h12, 8'h00);
    rd(7'h20, d);
    rd(7'h37, e);
    eng_addr = 6'h20;
    idle(2);
    #1;
    chk(eng_rdata, ~d, "engine user word");
    eng_addr = 6'h17;
    idle(2);
    #1;
    chk(eng_rdata, e, "engine last cs word");
    wr(7'h13, 8'h00);
    wr(7'h12, 8'h20);
    rd(7'h20, 8'h00);
    wr(7'h20, 8'h5a);
    wr(7'h13, 8'h04);
    rd(7'h20, ~d);
    $display("Test done: buffer window and banks");
    wr(7'h09, 8'h80);
    for (int m = 0; m < 4; m++) begin
      wr(7'h0a, {m[1], 7'h00});
      wr(7'h0b, {m[0], 7'h00});
      slip_ev = 1'b1;
      idle(3);
      #1;
      if (m == 0) chk({7'h00, irq_pin}, 8'h01, "irq pin on rise");
      rd(7'h07, (m != 1) ? 8'h80 : 8'h00);
      slip_ev = 1'b0;
      idle(3);
      rd(7'h07, (m == 1 || m == 2) ? 8'h80 : 8'h00);
      rd(7'h07, 8'h00);
      idle(4);
      #1;
      chk({7'h00, irq_pin}, 8'h00, "irq pin after clear");
    end
    $display("Test done: trigger modes");
    wr(7'h01, 8'h02);
    idle(2);
    #1;
    chk({6'h00, irq_oe_n, irq_pin}, 8'h01, "active low idle");
    wr(7'h0a, 8'h80);
    wr(7'h0b, 8'h00);
    slip_ev = 1'b1;
    idle(3);
    #1;
    chk({6'h00, irq_oe_n, irq_pin}, 8'h00, "active low level");
    slip_ev = 1'b0;
    rd(7'h07, 8'h80);
    rd(7'h07, 8'h00);
    wr(7'h01, 8'h04);
    idle(2);
    #1;
    chk({6'h00, irq_oe_n, irq_pin}, 8'h02, "open drain idle");
    wr(7'h01, 8'h00);
    wr(7'h09, 8'h00);
    wr(7'h0a, 8'h00);
    slip_ev = 1'b1;
    idle(3);
    #1;
    chk({7'h00, irq_pin}, 8'h00, "masked pin");
    rd(7'h07, 8'h00);
    slip_ev = 1'b0;
    $display("Test done: polarity and mask");
    idle(6);
    chk(8'(exp_q.size()), 8'h00, "answers outstanding");
    conclude();
  end
endmodule

`default_nettype wire
